// >>> pkg/spi_loop_regs.svh
// Offsets, field positions, resets and counts of the loop pointer
// Assumes inclusion by bare name; definitions only
`ifndef SPI_LOOP_REGS_SVH
`define SPI_LOOP_REGS_SVH
`define ADDR_FIRST    5'h00
`define ADDR_LAST     5'h1F
`define LAST_RO_ADDR  5'h07
`define FIRST_WR_ADDR 5'h08
`define LOCK_ADDR     5'h1F
`define LOCK_KEY      8'hA5
`define PHASE_ADDR    5'h0A
`define GROUP_MASK    5'h1C
`define LOOP_STATIC   2'h0
`define LOOP_GROUPS   2'h1
`define LOOP_TYPES    2'h2
`define LOOP_FULL     2'h3
`define WIDTH_16      2'h0
`define WIDTH_24      2'h1
`define LEN_16        6'h10
`define LEN_24        6'h18
`define LEN_32        6'h20
`define CMD_LAST_BIT  6'h07
`define CMD_DEV_HI    7
`define CMD_DEV_LO    6
`define CMD_REG_HI    5
`define CMD_REG_LO    1
`define CMD_RW        0
`define DEV_ADDR_DEF  2'h1
`define SETTLE_TICKS  17'h0_0030
`endif

// >>> pkg/spi_loop_pkg.sv
// Types of the loop pointer and ready pulse generator
// Assumes constants come from spi_loop_regs.svh
package spi_loop_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_READ, ST_WRITE, ST_SKIP} spi_state_type;

  typedef struct packed {
    spi_state_type st;
    logic          armed;
    logic          sck;
    logic          cpol;
    logic          pulse;
    logic [6:0]    cmd;
    logic [5:0]    cnt;
    logic [4:0]    ptr;
    logic [31:0]   sh;
    logic          sdo;
    logic          sdo_oe_n;
    logic          wr_stb;
    logic [4:0]    wr_addr;
    logic [31:0]   wr_data;
    logic          seq_end;
    logic [6:0]    cfg;
    logic [3:0]    restart;
    logic          clr;
    logic          rdy_n;
    logic          rdy_oe_n;
  } spi_reg_type;

  typedef struct packed {
    logic        mclk;
    logic        rclk;
    logic        settling;
    logic        rate_pend;
    logic        pulse;
    logic [16:0] cnt;
  } rdy_reg_type;
endpackage

// >>> pkg/ready_link_if.sv
// Link between the pointer top and the ready pulse generator
// Assumes both ends run on the one system clock
`timescale 1ns/1ps
interface ready_link_if;
  logic        mod_clk;
  logic        rate_clk;
  logic        hw_reset_n;
  logic        restart;
  logic [15:0] phase_delay;
  logic        pulse;
  modport top (output mod_clk, rate_clk, hw_reset_n, restart, phase_delay, input pulse);
  modport gen (input mod_clk, rate_clk, hw_reset_n, restart, phase_delay, output pulse);
endinterface

// >>> rtl/ready_pulse_gen.sv
// Ready pulse timing from modulator and output-rate clock levels
// Assumes both clock levels are synchronous samples on clk
`timescale 1ns/1ps
`include "spi_loop_regs.svh"

module ready_pulse_gen
  import spi_loop_pkg::*;
(
  input wire logic   clk,
  input wire logic   rst,
  ready_link_if.gen  link
);
  localparam rdy_reg_type RDY_RST = '{settling: 1'b1, cnt: `SETTLE_TICKS, default: '0};

  rdy_reg_type q;
  rdy_reg_type d;
  logic        m_rise;
  logic        m_fall;
  logic        r_rise;

  assign m_rise = link.mod_clk & ~q.mclk;
  assign m_fall = ~link.mod_clk & q.mclk;
  assign r_rise = link.rate_clk & ~q.rclk;
  assign link.pulse = q.pulse;

  // =====================================================
  // Pulse timing, blind to the serial session
  always_comb begin
    d      = q;
    d.mclk = link.mod_clk;
    d.rclk = link.rate_clk;
    if (r_rise) begin
      d.rate_pend = 1'b1;
    end
    if (m_fall) begin
      d.pulse = 1'b0;
    end
    if (m_rise) begin
      if (q.settling) begin
        if (q.cnt == 17'h0_0000) begin
          d.settling  = 1'b0;
          d.pulse     = 1'b1;
          d.rate_pend = 1'b0;
        end else begin
          d.cnt = q.cnt - 17'h0_0001;
        end
      end else if (q.rate_pend || r_rise) begin
        d.pulse     = 1'b1;
        d.rate_pend = 1'b0;
      end
    end
    if (!link.hw_reset_n || link.restart) begin
      d.settling  = 1'b1;
      d.pulse     = 1'b0;
      d.rate_pend = 1'b0;
      d.cnt       = `SETTLE_TICKS + {1'b0, link.phase_delay};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= RDY_RST;
    end else begin
      q <= d;
    end
  end

  // =====================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_pulse_fall;
    q.pulse && m_fall;
  endsequence
  property p_pulse_half;
    s_pulse_fall |=> !q.pulse;
  endproperty
  a_pulse_half: assert property (p_pulse_half) else $error("Pulse outlived modulator half period");
  property p_settle_quiet;
    q.settling |-> !q.pulse;
  endproperty
  a_settle_quiet: assert property (p_settle_quiet) else $error("Pulse during settling");
  property p_hw_quiet;
    !link.hw_reset_n |=> !q.pulse && q.settling;
  endproperty
  a_hw_quiet: assert property (p_hw_quiet) else $error("Pulse while reset pin low");
endmodule

// >>> rtl/spi_loop_pointer.sv
// Serial command decoder with looping register pointer and ready pin
// Assumes pins are synchronous to clk; register map lies outside
`timescale 1ns/1ps
`include "spi_loop_regs.svh"

module spi_loop_pointer
  import spi_loop_pkg::*;
#(
  parameter logic [1:0] DEV_ADDR = `DEV_ADDR_DEF
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cs_n,
  input  wire logic        sck,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe_n,
  input  wire logic [1:0]  read_loop,
  input  wire logic        write_loop,
  input  wire logic [1:0]  width_sel,
  input  wire logic [7:0]  lock_key,
  input  wire logic [31:0] rd_data,
  output logic [4:0]       reg_addr,
  output logic             wr_strobe,
  output logic [4:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic             seq_end,
  input  wire logic [2:0]  oversampling_ratio_field,
  input  wire logic [1:0]  prescale,
  input  wire logic        external_clock_select,
  input  wire logic        external_reference_select,
  input  wire logic [3:0]  channel_active,
  output logic [3:0]       adc_restart,
  output logic             data_clear,
  input  wire logic        hw_reset_n,
  input  wire logic        modulator_clock,
  input  wire logic        output_rate_clock,
  input  wire logic [15:0] phase_delay,
  input  wire logic        config_checksum_flag,
  input  wire logic        ready_idle_drive_select,
  output logic             sample_ready_n,
  output logic             sample_ready_oe_n
);
  localparam spi_reg_type SPI_RST = '{
    st:       ST_IDLE,
    sdo_oe_n: 1'b1,
    rdy_n:    1'b1,
    rdy_oe_n: 1'b1,
    default:  '0
  };

  spi_reg_type q;
  spi_reg_type d;
  logic        rise;
  logic        fall;
  logic        rdy_fall;
  logic        wend;
  logic        writable;
  logic        phase_wr;
  logic        cfg_trig;
  logic [5:0]  wlen;
  logic [31:0] word;
  logic [7:0]  cmd_byte;
  logic [6:0]  cfg_now;
  logic [1:0]  loop_sel;

  ready_link_if link ();

  ready_pulse_gen u_ready (
    .clk  (clk),
    .rst  (rst),
    .link (link)
  );

  // =====================================================
  // Next pointer inside the selected set
  function automatic logic [5:0] step(input logic [4:0] p, input logic [1:0] sel);
    logic [4:0] first;
    logic [4:0] last;
    first = p;
    last  = p;
    unique case (sel)
      `LOOP_STATIC: begin
        first = p;
      end
      `LOOP_GROUPS: begin
        first = p & `GROUP_MASK;
        last  = first | ~`GROUP_MASK;
      end
      `LOOP_TYPES: begin
        first = (p > `LAST_RO_ADDR) ? `FIRST_WR_ADDR : `ADDR_FIRST;
        last  = (p > `LAST_RO_ADDR) ? `ADDR_LAST : `LAST_RO_ADDR;
      end
      `LOOP_FULL: begin
        first = `ADDR_FIRST;
        last  = `ADDR_LAST;
      end
    endcase
    step = (p == last) ? {1'b1, first} : {1'b0, p + 5'h01};
  endfunction

  // =====================================================
  // Edges and decodes
  assign rise     = sck & ~q.sck;
  assign fall     = ~sck & q.sck;
  assign rdy_fall = link.pulse & ~q.pulse;
  assign cmd_byte = {q.cmd, sdi};
  assign cfg_now  = {oversampling_ratio_field, prescale, external_clock_select, external_reference_select};
  assign word     = rd_data << (`LEN_32 - wlen);

  // Word length per format
  assign wlen = (width_sel == `WIDTH_16) ? `LEN_16 :
                (width_sel == `WIDTH_24) ? `LEN_24 : `LEN_32;
  assign wend = rise && (q.cnt == wlen - 6'h01);

  // Write loop maps onto fixed or types
  assign loop_sel = (q.st == ST_WRITE) ? {write_loop, 1'b0} : read_loop;

  // Read-only range, and lock key gating
  assign writable = (q.ptr > `LAST_RO_ADDR) &&
                    (lock_key == `LOCK_KEY || q.ptr == `LOCK_ADDR);

  assign phase_wr = (q.st == ST_WRITE) && wend && writable && (q.ptr == `PHASE_ADDR);
  assign cfg_trig = q.armed && (phase_wr || cfg_now != q.cfg);

  // =====================================================
  // Next state
  always_comb begin
    d         = q;
    d.armed   = 1'b1;
    d.sck     = sck;
    d.pulse   = link.pulse;
    d.cfg     = cfg_now;
    d.wr_stb  = 1'b0;
    d.seq_end = 1'b0;
    d.restart = 4'h0;
    d.clr     = 1'b0;
    unique case (q.st)
      ST_IDLE: begin
        d.cpol = sck;
        d.st   = ST_CMD;
      end
      ST_CMD: begin
        if (rise) begin
          d.cmd = cmd_byte[6:0];
          d.cnt = q.cnt + 6'h01;
          if (q.cnt == `CMD_LAST_BIT) begin
            d.cnt = 6'h00;
            d.ptr = cmd_byte[`CMD_REG_HI:`CMD_REG_LO];
            if (cmd_byte[`CMD_DEV_HI:`CMD_DEV_LO] != DEV_ADDR) begin
              d.st = ST_SKIP;
            end else if (cmd_byte[`CMD_RW]) begin
              d.st       = ST_READ;
              d.sdo_oe_n = 1'b0;
            end else begin
              d.st = ST_WRITE;
            end
          end
        end
      end
      ST_READ: begin
        // Serial input is not looked at here
        if (fall) begin
          if (q.cnt == 6'h00) begin
            d.sdo = word[31];
            d.sh  = {word[30:0], 1'b0};
          end else begin
            d.sdo = q.sh[31];
            d.sh  = {q.sh[30:0], 1'b0};
          end
        end
        // Idle-low clock: fresh MSB at ready fall
        if (rdy_fall && !q.cpol && !sck && q.cnt == 6'h00) begin
          d.sdo = word[31];
          d.sh  = {word[30:0], 1'b0};
        end
        if (wend) begin
          d.cnt                = 6'h00;
          {d.seq_end, d.ptr}   = step(q.ptr, loop_sel);
        end else if (rise) begin
          d.cnt = q.cnt + 6'h01;
        end
      end
      ST_WRITE: begin
        if (rise) begin
          d.sh  = {q.sh[30:0], sdi};
          d.cnt = q.cnt + 6'h01;
        end
        if (wend) begin
          d.cnt = 6'h00;
          d.sh  = 32'h0000_0000;
          if (writable) begin
            d.wr_stb             = 1'b1;
            d.wr_addr            = q.ptr;
            d.wr_data            = {q.sh[30:0], sdi};
            {d.seq_end, d.ptr}   = step(q.ptr, loop_sel);
          end
          // Otherwise dropped and pointer held
        end
      end
      ST_SKIP: begin
        d.cnt = 6'h00;
      end
    endcase

    // Deselect resets the serial side
    if (cs_n) begin
      d.st       = ST_IDLE;
      d.sdo_oe_n = 1'b1;
      d.cnt      = 6'h00;
      d.cmd      = 7'h00;
      d.sh       = 32'h0000_0000;
    end

    // Restart of active converters
    if (cfg_trig) begin
      d.restart = channel_active;
      d.clr     = |channel_active;
    end

    // Ready pin drive
    if (!hw_reset_n) begin
      d.rdy_n    = 1'b1;
      d.rdy_oe_n = ~ready_idle_drive_select;
    end else if (config_checksum_flag || link.pulse) begin
      d.rdy_n    = 1'b0;
      d.rdy_oe_n = 1'b0;
    end else begin
      d.rdy_n    = 1'b1;
      d.rdy_oe_n = ~ready_idle_drive_select;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= SPI_RST;
    end else begin
      q <= d;
    end
  end

  // =====================================================
  // Outputs and link
  assign sdo               = q.sdo;
  assign sdo_oe_n          = q.sdo_oe_n;
  assign reg_addr          = q.ptr;
  assign wr_strobe         = q.wr_stb;
  assign wr_addr           = q.wr_addr;
  assign wr_data           = q.wr_data;
  assign seq_end           = q.seq_end;
  assign adc_restart       = q.restart;
  assign data_clear        = q.clr;
  assign sample_ready_n    = q.rdy_n;
  assign sample_ready_oe_n = q.rdy_oe_n;

  assign link.mod_clk     = modulator_clock;
  assign link.rate_clk    = output_rate_clock;
  assign link.hw_reset_n  = hw_reset_n;
  assign link.phase_delay = phase_delay;
  assign link.restart     = |q.restart;

  // =====================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_deselect;
    cs_n && q.st != ST_IDLE;
  endsequence
  property p_cs_abort;
    s_deselect |=> q.st == ST_IDLE && sdo_oe_n;
  endproperty
  a_cs_abort: assert property (p_cs_abort) else $error("Deselect did not abort session");

  property p_one_cmd;
    (q.st == ST_READ || q.st == ST_WRITE) && !cs_n |=> q.st == $past(q.st);
  endproperty
  a_one_cmd: assert property (p_one_cmd) else $error("Session left its loop while selected");

  property p_write_hiz;
    q.st == ST_WRITE |-> sdo_oe_n;
  endproperty
  a_write_hiz: assert property (p_write_hiz) else $error("Output driven during write");

  property p_lock;
    wr_strobe |-> wr_addr == `LOCK_ADDR || $past(lock_key) == `LOCK_KEY;
  endproperty
  a_lock: assert property (p_lock) else $error("Write passed while locked");

  sequence s_blocked;
    q.st == ST_WRITE && wend && !writable;
  endsequence
  property p_no_adv;
    s_blocked |=> $stable(q.ptr) && !wr_strobe;
  endproperty
  a_no_adv: assert property (p_no_adv) else $error("Blocked write moved pointer");

  property p_ro;
    wr_strobe |-> wr_addr > `LAST_RO_ADDR;
  endproperty
  a_ro: assert property (p_ro) else $error("Write to read-only address");

  sequence s_full_last;
    q.st == ST_READ && wend && loop_sel == `LOOP_FULL && q.ptr == `ADDR_LAST;
  endsequence
  property p_wrap;
    s_full_last |=> q.ptr == `ADDR_FIRST && seq_end;
  endproperty
  a_wrap: assert property (p_wrap) else $error("Pointer did not wrap at set end");

  property p_step;
    q.st == ST_READ && wend && loop_sel == `LOOP_FULL && q.ptr != `ADDR_LAST
      |=> q.ptr == $past(q.ptr) + 5'h01 && !seq_end;
  endproperty
  a_step: assert property (p_step) else $error("Pointer did not step by one");

  property p_static;
    q.st == ST_READ && wend && loop_sel == `LOOP_STATIC |=> $stable(q.ptr);
  endproperty
  a_static: assert property (p_static) else $error("Fixed loop moved pointer");

  property p_restart;
    phase_wr && q.armed |=> adc_restart == $past(channel_active);
  endproperty
  a_restart: assert property (p_restart) else $error("Phase write gave no restart");

  property p_crc_low;
    hw_reset_n && config_checksum_flag |=> !sample_ready_n && !sample_ready_oe_n;
  endproperty
  a_crc_low: assert property (p_crc_low) else $error("Ready not held low on checksum flag");

  property p_rst_idle;
    !hw_reset_n |=> sample_ready_n && sample_ready_oe_n == !$past(ready_idle_drive_select);
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("Ready active while reset pin low");
endmodule

// >>> verif/spi_host_model.sv
// Host side serial master model for the loop pointer
// Assumes clk is the system clock and pins are sampled by the device on clk
`timescale 1ns/1ps

module spi_host_model (
  input  wire logic clk,
  output logic      cs_n,
  output logic      sck,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe_n
);
  logic [31:0] tx [8];
  logic [31:0] rx [8];
  logic        oe_seen;
  logic        last_sdo;
  logic        cpol;

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
    cpol = 1'b0;
    oe_seen = 1'b0;
    last_sdo = 1'b0;
  end

  always @(posedge clk) begin
    if (cs_n === 1'b0 && sdo_oe_n === 1'b0) oe_seen <= 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One bit: fall, data setup, sample and rise, back to idle level
  task automatic bit_x(input logic b, output logic r);
    if (cpol) sck = 1'b0;
    sdi = b;
    tick(3);
    // Released line shows the inverse of its last level
    r = sdo_oe_n ? ~sdo : sdo;
    sck = 1'b1;
    tick(3);
    if (!cpol) sck = 1'b0;
  endtask

  // ==========================================================
  // Frame: one command byte, then nw words of wl bits
  task automatic frame(input logic [7:0] cmd, input int nw, input int wl);
    logic        r;
    logic [31:0] w;
    sck = cpol;
    tick(1);
    cs_n = 1'b0;
    oe_seen = 1'b0;
    tick(2);
    for (int i = 7; i >= 0; i--) bit_x(cmd[i], r);
    for (int k = 0; k < nw; k++) begin
      w = 32'h0000_0000;
      for (int i = wl - 1; i >= 0; i--) begin
        bit_x(tx[k][i], r);
        w[i] = r;
      end
      rx[k] = w;
    end
    tick(3);
    last_sdo = sdo_oe_n ? ~sdo : sdo;
    cs_n = 1'b1;
    sdi = ~sdi;
    tick(3);
  endtask
endmodule

// >>> verif/tb_top.sv
// Self-checking bench of the loop pointer and ready pin
// Assumes spi_host_model drives the serial pins; register map modelled here
`timescale 1ns/1ps

module tb_top;
  localparam logic [1:0] DEV = 2'h1;
  logic        clk, rst, cs_n, sck, sdi, sdo, sdo_oe_n;
  logic [1:0]  read_loop, width_sel, prescale;
  logic        write_loop, wr_strobe, seq_end, data_clear, hw_reset_n;
  logic [7:0]  lock_key, ck;
  logic [31:0] rd_data, wr_data, e;
  logic [4:0]  reg_addr, wr_addr, a, b;
  logic [2:0]  oversampling_ratio_field;
  logic        external_clock_select, external_reference_select, config_checksum_flag;
  logic [3:0]  channel_active, adc_restart, rs_val;
  logic [15:0] phase_delay;
  logic        modulator_clock, output_rate_clock, ready_idle_drive_select;
  logic        sample_ready_n, sample_ready_oe_n;
  logic [36:0] wq[$];
  int          error_cnt, check_count, se_cnt, rs_cnt, dc_cnt, n, w, c;

  spi_loop_pointer #(.DEV_ADDR(DEV)) i_dut (
    .clk, .rst, .cs_n, .sck, .sdi, .sdo, .sdo_oe_n, .read_loop, .write_loop, .width_sel,
    .lock_key, .rd_data, .reg_addr, .wr_strobe, .wr_addr, .wr_data, .seq_end,
    .oversampling_ratio_field, .prescale, .external_clock_select, .external_reference_select,
    .channel_active, .adc_restart, .data_clear, .hw_reset_n, .modulator_clock,
    .output_rate_clock, .phase_delay, .config_checksum_flag, .ready_idle_drive_select,
    .sample_ready_n, .sample_ready_oe_n);
  spi_host_model i_host (.clk, .cs_n, .sck, .sdi, .sdo, .sdo_oe_n);

  function automatic logic [31:0] map(input logic [4:0] x);
    return {4{3'h5, x}};
  endfunction

  // Expected next address of a loop set
  function automatic logic [4:0] nxt(input logic [4:0] x, input logic [1:0] l);
    case (l)
      2'h0: return x;
      2'h1: return {x[4:2], x[1:0] + 2'h1};
      2'h2: return (x == 5'h07) ? 5'h00 : (x == 5'h1F) ? 5'h08 : x + 5'h01;
      default: return x + 5'h01;
    endcase
  endfunction

  assign rd_data = map(reg_addr);
  assign modulator_clock = ck[2];
  assign output_rate_clock = ck[5];
  always #4 clk = ~clk;

  always @(posedge clk) begin
    #1;
    ck <= ck + 8'h01;
  end

  always @(posedge clk) begin
    if (wr_strobe === 1'b1) wq.push_back({wr_addr, wr_data});
    if (seq_end === 1'b1) se_cnt++;
    if (adc_restart !== 4'h0) begin
      rs_cnt++;
      rs_val = adc_restart;
      if (data_clear === 1'b1) dc_cnt++;
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
    check_count++;
    if (s !== ex) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, ex, s);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic run(input logic [4:0] x, input logic rw, input int nw, input int wl);
    se_cnt = 0;
    wq.delete();
    i_host.frame({DEV, x, rw}, nw, wl);
  endtask

  task automatic wcheck(input logic [4:0] x, input int nw, input int wl, input int ne);
    logic [31:0] mk;
    mk = (wl == 32) ? 32'hFFFF_FFFF : (32'h0000_0001 << wl) - 32'h0000_0001;
    run(x, 1'b0, nw, wl);
    chk("write count", ne, wq.size());
    for (int k = 0; k < ne && k < wq.size(); k++) begin
      chk("write addr", {27'h0, x}, {27'h0, wq[k][36:32]});
      chk("write data", i_host.tx[k] & mk, wq[k][31:0]);
      x = nxt(x, {write_loop, 1'b0});
    end
    chk("sdo enable in write", 0, i_host.oe_seen);
  endtask

  task automatic wait_fall(output int k);
    k = 0;
    while (sample_ready_n !== 1'b1 && k < 2000) begin
      tick(1);
      k++;
    end
    while (sample_ready_n !== 1'b0 && k < 2000) begin
      tick(1);
      k++;
    end
    if (k >= 2000) begin
      error_cnt++;
      $display("[ERR] ready pulse expected 1 seen 0");
      close_out();
    end
  endtask

  task automatic count_lvl(input logic v, input int len, output int k);
    k = 0;
    repeat (len) begin
      tick(1);
      if (sample_ready_n === v) k++;
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    ck = 8'h00;
    read_loop = 2'h2;
    write_loop = 1'b1;
    width_sel = 2'h1;
    lock_key = 8'hA5;
    prescale = 2'h0;
    oversampling_ratio_field = 3'h0;
    external_clock_select = 1'b0;
    external_reference_select = 1'b0;
    channel_active = 4'h5;
    hw_reset_n = 1'b1;
    phase_delay = 16'h0001;
    config_checksum_flag = 1'b0;
    ready_idle_drive_select = 1'b1;
    for (int k = 0; k < 8; k++) i_host.tx[k] = 32'h9E37_79B9 ^ {4{k[7:0]}};
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    tick(2);

    for (int p = 0; p < 2; p++) begin
      for (int l = 0; l < 4; l++) begin
        i_host.cpol = p[0];
        read_loop = l[1:0];
        // Full map starts near the top to cross the wrap
        a = (l == 3) ? 5'h1E : 5'h06;
        run(a, 1'b1, 3, 24);
        for (int k = 0; k < 3; k++) begin
          chk("read word", map(a) & 32'h00FF_FFFF, i_host.rx[k]);
          b = a;
          a = nxt(a, l[1:0]);
        end
        chk("seq_end count", (l == 0) ? 3 : 1, se_cnt);
        chk("sdo enable in read", 1, i_host.oe_seen);
        e = (p == 1) ? map(b) : (map(a) >> 23);
        chk("idle sdo", e & 32'h1, i_host.last_sdo);
      end
    end
    i_host.frame({2'h2, 5'h06, 1'b1}, 1, 24);
    chk("foreign enable", 0, i_host.oe_seen);
    $display("test read loops done");

    width_sel = 2'h0;
    wcheck(5'h1E, 3, 16, 3);
    chk("write seq_end", 1, se_cnt);
    write_loop = 1'b0;
    width_sel = 2'h2;
    wcheck(5'h0C, 2, 32, 2);
    width_sel = 2'h0;
    wcheck(5'h03, 2, 16, 0);
    chk("held pointer", 5'h03, reg_addr);
    c = rs_cnt;
    wcheck(5'h0A, 2, 16, 2);
    chk("phase restarts", c + 2, rs_cnt);
    lock_key = 8'h00;
    wcheck(5'h0C, 1, 16, 0);
    wcheck(5'h1F, 1, 16, 1);
    lock_key = 8'hA5;
    $display("test writes done");

    for (int i = 0; i < 4; i++) begin
      c = rs_cnt;
      case (i)
        0: oversampling_ratio_field = 3'h3;
        1: prescale = 2'h2;
        2: external_clock_select = 1'b1;
        default: external_reference_select = 1'b1;
      endcase
      tick(4);
      chk("restart count", c + 1, rs_cnt);
      chk("restart set", {28'h0, channel_active}, {28'h0, rs_val});
    end
    chk("clear count", rs_cnt, dc_cnt);
    $display("test restarts done");

    wait_fall(n);
    // First pulse may be the settling one, off the rate grid
    wait_fall(n);
    w = 0;
    while (sample_ready_n === 1'b0 && w < 50) begin
      chk("ready enable low", 0, sample_ready_oe_n);
      tick(1);
      w++;
    end
    chk("pulse width", 4, w);
    wait_fall(n);
    chk("pulse period", 64, n + w);
    tick(8);
    chk("idle driven", 0, sample_ready_oe_n);
    ready_idle_drive_select = 1'b0;
    tick(2);
    chk("idle float", 1, sample_ready_oe_n);
    hw_reset_n = 1'b0;
    count_lvl(1'b0, 200, n);
    chk("lows in pin reset", 0, n);
    hw_reset_n = 1'b1;
    wait_fall(n);
    chk("first pulse delay", 1, n >= 384 && n <= 416);
    config_checksum_flag = 1'b1;
    tick(3);
    count_lvl(1'b1, 150, n);
    chk("highs while flagged", 0, n);
    config_checksum_flag = 1'b0;
    $display("test ready pin done");
    close_out();
  end
endmodule
